// File: src/dual_serial_port.v
// two full-duplex serial ports with select-mode pin logic and apb registers
//
// Functional notes
// - two identical serial ports are built, each shifting in and out at once.
// - as master the master-out pin is driven from the shift register msb.
// - every byte moves msb first on both data lines in both roles.
// - the slave-out pin is released when disabled or as an unselected 4-wire slave.
// - as a 3-wire slave the slave-out pin is always driven from the shift msb.
// - the serial clock is driven only as master and is an input as slave.
// - a 4-wire slave ignores all serial clock edges while its select is high.
// - select mode 00 is 3-wire with the select unused and a slave always selected.
// - select mode 01 is 4-wire with the select input choosing the slave.
// - a master in select mode 01 loses its master function on a falling select.
// - select mode 1x drives the select pin out at the low bit of the mode field.
// - the select pin is requested from pin routing in every mode but 3-wire.
// - a mode fault clears master and port enable and sets the mode fault flag.
// - the transfer complete flag is set after each byte and cleared by software.
// - a falling select resets a 4-wire slave bit counter; select and clock pass the same two-flop synchroniser.
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module dual_serial_port (
    input  wire                pclk,
    input  wire                presetn,
    input  wire                ce,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [`APB_AW-1:0]  paddr,
    input  wire [31:0]         pwdata,
    output wire [31:0]         prdata,
    output wire                pready,
    output wire                pslverr,
    output wire                irq,
    input  wire [1:0]          sck_i,
    input  wire [1:0]          mosi_i,
    input  wire [1:0]          miso_i,
    input  wire [1:0]          nss_i,
    output wire [1:0]          sck_o,
    output wire [1:0]          sck_oe,
    output wire [1:0]          mosi_o,
    output wire [1:0]          mosi_oe,
    output wire [1:0]          miso_o,
    output wire [1:0]          miso_oe,
    output wire [1:0]          nss_o,
    output wire [1:0]          nss_oe,
    output wire [1:0]          nss_route
);

    // true when the address hits register off of port prt
    function reg_hit;
        input [`APB_AW-1:0] addr;
        input integer       prt;
        input [3:0]         off;
        begin
            reg_hit = (addr[`APB_AW-1:`PORT_SEL_BIT+1] == {(`APB_AW-`PORT_SEL_BIT-1){1'b0}})
                      && (addr[`PORT_SEL_BIT] == (prt == 1))
                      && (addr[`PORT_SEL_BIT-1:0] == off);
        end
    endfunction

    wire        setup_ph;
    wire        access_ph;
    wire        mapped;
    wire [63:0] rd_vec;
    wire [1:0]  irq_vec;
    wire [7:0]  pin_raw;
    wire [7:0]  pin_s;
    reg  [7:0]  pin_d_ff;
    reg  [31:0] prdata_ff;

    // the bus waits while the block is frozen, so no write is lost
    assign pready    = ce;
    assign setup_ph  = psel & ~penable & ce;
    assign access_ph = psel & penable & ce;
    assign mapped    = (paddr[`APB_AW-1:`PORT_SEL_BIT+1]
                        == {(`APB_AW-`PORT_SEL_BIT-1){1'b0}});
    assign pslverr   = psel & penable & ~mapped;
    assign prdata    = prdata_ff;
    assign irq       = |irq_vec;

    assign pin_raw = {nss_i, miso_i, mosi_i, sck_i};

    pin_sync #(
        .WIDTH (`PINS_PER_PORT * 2)
    ) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     (pin_raw),
        .dout    (pin_s)
    );

    // third stage only for edge detection on the synchronised levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_d_ff <= 8'h00;
        end else if (ce) begin
            pin_d_ff <= pin_s;
        end
    end

    // read data is captured in the setup phase and held through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (setup_ph & ~pwrite) begin
            if (!mapped) begin
                prdata_ff <= 32'h00000000;
            end else if (paddr[`PORT_SEL_BIT]) begin
                prdata_ff <= rd_vec[63:32];
            end else begin
                prdata_ff <= rd_vec[31:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : port
            reg        en_ff;
            reg        mst_ff;
            reg [1:0]  md_ff;
            reg [7:0]  div_ff;
            reg [7:0]  sh_ff;
            reg [7:0]  txb_ff;
            reg [7:0]  rxb_ff;
            reg        tx_full_ff;
            reg        rx_full_ff;
            reg        loaded_ff;
            reg        busy_ff;
            reg        sck_ff;
            reg        rxbit_ff;
            reg        rd_full_ff;
            reg [2:0]  cnt_ff;
            reg [7:0]  dcnt_ff;
            reg [3:0]  st_ff;
            reg [3:0]  mask_ff;
            reg [31:0] rd_word;

            wire s_sck;
            wire s_mosi;
            wire s_miso;
            wire s_nss;
            wire sck_rise;
            wire sck_fall;
            wire nss_fall;
            wire slv;
            wire selected;
            wire fault;
            wire tick;
            wire sample;
            wire shift_now;
            wire done;
            wire ovr;
            wire wcol;
            wire load;
            wire bit_in;
            wire [7:0] byte_in;
            wire wr_ctrl;
            wire wr_data;
            wire wr_stat;
            wire wr_mask;
            wire rd_data;
            wire rd_clear;
            wire [3:0] st_set;
            wire [3:0] st_clr;

            assign s_sck  = pin_s[g];
            assign s_mosi = pin_s[2+g];
            assign s_miso = pin_s[4+g];
            assign s_nss  = pin_s[6+g];

            assign sck_rise = s_sck & ~pin_d_ff[g];
            assign sck_fall = ~s_sck & pin_d_ff[g];
            assign nss_fall = ~s_nss & pin_d_ff[6+g];

            assign slv      = en_ff & ~mst_ff;
            // a select-output mode counts as unselected for a slave
            assign selected = (md_ff == `MD_3WIRE)
                              | ((md_ff == `MD_4WIRE_IN) & ~s_nss);
            assign fault    = en_ff & mst_ff & (md_ff == `MD_4WIRE_IN) & nss_fall;

            assign tick      = busy_ff & (dcnt_ff == div_ff);
            // clock phase 0, polarity 0: sample on rise, shift on fall
            assign sample    = (tick & ~sck_ff) | (slv & selected & sck_rise);
            assign shift_now = (tick & sck_ff) | (slv & selected & sck_fall);
            assign done      = shift_now & (cnt_ff == `BIT_LAST);
            assign bit_in    = mst_ff ? s_miso : s_mosi;
            assign byte_in   = {sh_ff[6:0], rxbit_ff};

            assign wr_ctrl = access_ph & pwrite & reg_hit(paddr, g, `REG_CTRL);
            assign wr_data = access_ph & pwrite & reg_hit(paddr, g, `REG_DATA);
            assign wr_stat = access_ph & pwrite & reg_hit(paddr, g, `REG_STAT);
            assign wr_mask = access_ph & pwrite & reg_hit(paddr, g, `REG_MASK);
            assign rd_data = psel & ~pwrite & reg_hit(paddr, g, `REG_DATA);
            // only a byte that was already visible at setup is consumed
            assign rd_clear = access_ph & rd_data & rd_full_ff;

            assign wcol = wr_data & tx_full_ff;
            assign ovr  = done & slv & rx_full_ff & ~rd_clear;
            // slave reloads only between bytes so a shift never overwrites it
            assign load = en_ff & tx_full_ff & ~shift_now
                          & (mst_ff ? ~busy_ff : (~loaded_ff & (cnt_ff == 3'h0)));

            assign st_set = {ovr, wcol, fault, done};
            assign st_clr = wr_stat ? pwdata[`ST_OVR:`ST_DONE] : 4'h0;

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    en_ff      <= 1'b0;
                    mst_ff     <= 1'b0;
                    md_ff      <= `RST_MD;
                    div_ff     <= `RST_DIV;
                    sh_ff      <= 8'h00;
                    txb_ff     <= 8'h00;
                    rxb_ff     <= 8'h00;
                    tx_full_ff <= 1'b0;
                    rx_full_ff <= 1'b0;
                    loaded_ff  <= 1'b0;
                    busy_ff    <= 1'b0;
                    sck_ff     <= 1'b0;
                    rxbit_ff   <= 1'b0;
                    rd_full_ff <= 1'b0;
                    cnt_ff     <= 3'h0;
                    dcnt_ff    <= 8'h00;
                    st_ff      <= 4'h0;
                    mask_ff    <= 4'h0;
                end else if (ce) begin
                    // a fault beats a control write in the same cycle
                    if (fault) begin
                        en_ff  <= 1'b0;
                        mst_ff <= 1'b0;
                    end else if (wr_ctrl) begin
                        en_ff  <= pwdata[`CTRL_EN];
                        mst_ff <= pwdata[`CTRL_MST];
                        md_ff  <= pwdata[`CTRL_MD_HI:`CTRL_MD_LO];
                        div_ff <= pwdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
                    end

                    // a write into a full transmit buffer is dropped
                    if (wr_data & ~tx_full_ff) begin
                        txb_ff     <= pwdata[7:0];
                        tx_full_ff <= 1'b1;
                    end else if (load) begin
                        tx_full_ff <= 1'b0;
                    end

                    // disabling is the only way to realign a 3-wire slave
                    if (!en_ff) begin
                        cnt_ff    <= 3'h0;
                        busy_ff   <= 1'b0;
                        sck_ff    <= 1'b0;
                        dcnt_ff   <= 8'h00;
                        loaded_ff <= 1'b0;
                    end else begin
                        if (load) begin
                            sh_ff   <= txb_ff;
                            dcnt_ff <= 8'h00;
                            if (mst_ff) begin
                                busy_ff <= 1'b1;
                            end else begin
                                loaded_ff <= 1'b1;
                            end
                        end else if (busy_ff) begin
                            dcnt_ff <= tick ? 8'h00 : dcnt_ff + 8'h01;
                        end
                        if (tick) begin
                            sck_ff <= ~sck_ff;
                        end
                        if (sample) begin
                            rxbit_ff <= bit_in;
                        end
                        if (shift_now) begin
                            sh_ff  <= byte_in;
                            cnt_ff <= cnt_ff + 3'h1;
                        end
                        if (done) begin
                            busy_ff   <= 1'b0;
                            loaded_ff <= 1'b0;
                        end
                        if (slv & (md_ff == `MD_4WIRE_IN) & nss_fall) begin
                            cnt_ff <= 3'h0;
                        end
                    end

                    // receive buffer: an unread byte is kept on a slave overrun
                    if (done & ~ovr) begin
                        rxb_ff     <= byte_in;
                        rx_full_ff <= 1'b1;
                    end else if (rd_clear) begin
                        rx_full_ff <= 1'b0;
                    end
                    if (setup_ph & rd_data) begin
                        rd_full_ff <= rx_full_ff;
                    end

                    // sticky flags: a new event wins over a clear
                    st_ff <= (st_ff & ~st_clr) | st_set;
                    if (wr_mask) begin
                        mask_ff <= pwdata[`ST_OVR:`ST_DONE];
                    end
                end
            end

            always @* begin
                rd_word = 32'h00000000;
                if (reg_hit(paddr, g, `REG_CTRL)) begin
                    rd_word[`CTRL_EN]                  = en_ff;
                    rd_word[`CTRL_MST]                 = mst_ff;
                    rd_word[`CTRL_MD_HI:`CTRL_MD_LO]   = md_ff;
                    rd_word[`CTRL_DIV_HI:`CTRL_DIV_LO] = div_ff;
                end else if (reg_hit(paddr, g, `REG_DATA)) begin
                    rd_word[7:0] = rxb_ff;
                end else if (reg_hit(paddr, g, `REG_STAT)) begin
                    rd_word[`ST_OVR:`ST_DONE] = st_ff;
                    rd_word[`ST_RX_FULL]      = rx_full_ff;
                    rd_word[`ST_TX_FULL]      = tx_full_ff;
                    rd_word[`ST_BUSY]         = busy_ff | loaded_ff;
                end else if (reg_hit(paddr, g, `REG_MASK)) begin
                    rd_word[`ST_OVR:`ST_DONE] = mask_ff;
                end
            end

            assign rd_vec[g*32 +: 32] = rd_word;
            assign irq_vec[g]         = |(st_ff & mask_ff);

            assign sck_o[g]     = sck_ff;
            assign sck_oe[g]    = en_ff & mst_ff;
            assign mosi_o[g]    = sh_ff[7];
            assign mosi_oe[g]   = en_ff & mst_ff;
            assign miso_o[g]    = sh_ff[7];
            assign miso_oe[g]   = slv & selected;
            // select-output mode drives regardless of enable, as a chip select would
            assign nss_o[g]     = md_ff[0];
            assign nss_oe[g]    = md_ff[1];
            assign nss_route[g] = (md_ff != `MD_3WIRE);
        end
    endgenerate

endmodule // dual_serial_port

// File: src/pin_sync.v
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             ce,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // the first stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else if (ce) begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule // pin_sync

// File: src/serial_port_consts.vh
// constants shared by the dual serial port design files
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// apb register map: port n occupies byte offsets n*0x10 .. n*0x10+0xC
`define APB_AW        8
`define PORT_SEL_BIT  4
`define REG_CTRL      4'h0
`define REG_DATA      4'h4
`define REG_STAT      4'h8
`define REG_MASK      4'hC

// control register fields
`define CTRL_EN       0
`define CTRL_MST      1
`define CTRL_MD_LO    2
`define CTRL_MD_HI    3
`define CTRL_DIV_LO   8
`define CTRL_DIV_HI   15

// reset values
`define RST_MD        2'h1
`define RST_DIV       8'h01

// select mode field encodings
`define MD_3WIRE      2'h0
`define MD_4WIRE_IN   2'h1

// status and mask fields (same layout), live state above them
`define ST_DONE       0
`define ST_MODF       1
`define ST_WCOL       2
`define ST_OVR        3
`define ST_RX_FULL    4
`define ST_TX_FULL    5
`define ST_BUSY       6

// bit counter value of the last bit of a byte
`define BIT_LAST      3'h7

// synchronised pins per port: sck, mosi, miso, select
`define PINS_PER_PORT 4

`endif

// File: test/dual_serial_port_sva.sv
// pin and bus assertions for the dual serial port
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module dual_serial_port_sva (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pslverr,
    input wire logic               irq,
    input wire logic [1:0]         nss_i,
    input wire logic [1:0]         sck_oe,
    input wire logic [1:0]         mosi_oe,
    input wire logic [1:0]         miso_oe,
    input wire logic [1:0]         nss_o,
    input wire logic [1:0]         nss_oe,
    input wire logic [1:0]         nss_route
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;

    oe_pair_a: assert property (sck_oe == mosi_oe)
        else $error("clock and data drive differ");
    role_excl_a: assert property ((mosi_oe & miso_oe) == 2'h0)
        else $error("master and slave drive at once");
    route_out_a: assert property ((nss_oe & ~nss_route) == 2'h0)
        else $error("select driven but not routed");
    sel_level_a: assert property ($changed(nss_o) |-> $past(wr))
        else $error("select level moved without a write");
    modf_drop_a: assert property ($fell(nss_i[0]) && mosi_oe[0] && nss_route[0]
        && !nss_oe[0] |-> ##[1:6] !mosi_oe[0]) else $error("master kept bus");
    irq_clear_a: assert property ($fell(irq) |-> $past(wr))
        else $error("interrupt fell without a write");
    unmapped_rd_a: assert property (psel && penable && !pwrite && paddr[7:5] != 3'h0
        |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    unsel_miso_a: assert property ((nss_i[1] && nss_route[1] && !nss_oe[1])[*4]
        |-> !miso_oe[1]) else $error("unselected slave drives");

    cover property ($fell(mosi_oe[0]));
    cover property ($rose(irq));
    cover property ($rose(miso_oe[1]));
endmodule // dual_serial_port_sva

bind dual_serial_port dual_serial_port_sva sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .irq(irq), .nss_i(nss_i), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
    .nss_o(nss_o), .nss_oe(nss_oe), .nss_route(nss_route));

// File: test/dual_serial_port_tb_top.sv
// self-checking bench for the dual serial port
`timescale 1ns/1ps
module dual_serial_port_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, nss0_ext, slv;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    logic [7:0]  rb;
    integer      err_total, tests_run, edges;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, miso_m, sck_s, mosi_s, nss_s;
    wire  [1:0]  sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, nss_o, nss_oe, nss_route;
    // undriven lines rest at their pull level
    wire sck0 = sck_oe[0] ? sck_o[0] : 1'b0;
    wire mosi0 = mosi_oe[0] ? mosi_o[0] : 1'b0;
    wire nss0 = nss_oe[0] ? nss_o[0] : nss0_ext;
    wire sck1 = sck_oe[1] ? sck_o[1] : sck_s;
    wire mosi1 = mosi_oe[1] ? mosi_o[1] : mosi_s;
    wire miso1 = miso_oe[1] ? miso_o[1] : 1'b1;
    wire nss1 = nss_oe[1] ? nss_o[1] : nss_s;

    dual_serial_port dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sck_i({sck1, sck0}),
        .mosi_i({mosi1, mosi0}), .miso_i({miso1, miso_m}), .nss_i({nss1, nss0}),
        .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_o(miso_o),
        .miso_oe(miso_oe), .nss_o(nss_o), .nss_oe(nss_oe), .nss_route(nss_route));
    spi_far far (.sck_m(sck0), .mosi_m(mosi0), .sel_m(nss0), .miso_m(miso_m), .sck_s(sck_s),
        .mosi_s(mosi_s), .nss_s(nss_s), .miso_s(miso1));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge sck0) edges++;

    task chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pready !== 1'b1 && n < 50);
            chk(n < 50, "no ready");
            rd = prdata;
            slv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            #1;
        end
    endtask

    task t_reset;
        begin
            chk(nss_route === 2'h3, "route after reset");
            chk((sck_oe | mosi_oe | miso_oe | nss_oe) === 2'h0, "driven after reset");
            apb(1'b0, 8'h20, 32'h0);
            chk(slv === 1'b1 && rd === 32'h0, "unmapped read");
        end
    endtask

    task t_master;
        integer n;
        begin
            apb(1'b1, 8'h00, 32'h0000_070B);
            chk(nss_oe[0] === 1'b1 && nss_o[0] === 1'b0, "select out low");
            chk(sck_oe[0] === 1'b1 && mosi_oe[0] === 1'b1, "master drive");
            apb(1'b1, 8'h0C, 32'h1);
            edges = 0;
            apb(1'b1, 8'h04, 32'h3C);
            for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge pclk);
            chk(irq === 1'b1 && edges === 8, "byte length");
            chk(far.rx_m === 8'h3C, "mosi bits");
            apb(1'b0, 8'h04, 32'h0);
            chk(rd[7:0] === 8'hA5, "miso bits");
            apb(1'b1, 8'h0C, 32'h0);
            chk(irq === 1'b0, "masked");
            apb(1'b1, 8'h0C, 32'h1);
            apb(1'b1, 8'h08, 32'h1);
            chk(irq === 1'b0, "flag cleared");
            apb(1'b1, 8'h00, 32'h0000_070F);
            chk(nss_o[0] === 1'b1 && nss_route[0] === 1'b1, "select out high");
        end
    endtask

    task t_slave4;
        begin
            apb(1'b1, 8'h10, 32'h5);
            apb(1'b1, 8'h14, 32'h96);
            far.send(8'h5A, 1'b1, rb);
            chk(rb === 8'h96, "slave out bits");
            apb(1'b0, 8'h14, 32'h0);
            chk(rd[7:0] === 8'h5A, "slave in bits");
            chk(miso_oe[1] === 1'b0, "miso released");
            apb(1'b1, 8'h18, 32'hF);
            far.send(8'hFF, 1'b0, rb);
            apb(1'b0, 8'h18, 32'h0);
            chk(rd[0] === 1'b0 && miso_oe[1] === 1'b0, "unselected clock");
        end
    endtask

    task t_slave3;
        begin
            apb(1'b1, 8'h10, 32'h1);
            chk(nss_route[1] === 1'b0 && miso_oe[1] === 1'b1, "three-wire slave");
            far.send(8'hC3, 1'b0, rb);
            apb(1'b0, 8'h14, 32'h0);
            chk(rd[7:0] === 8'hC3, "always selected");
        end
    endtask

    task t_fault;
        begin
            apb(1'b1, 8'h00, 32'h0000_0707);
            @(posedge pclk);
            nss0_ext <= 1'b0;
            repeat (8) @(posedge pclk);
            #1 chk(mosi_oe[0] === 1'b0 && sck_oe[0] === 1'b0, "master dropped");
            apb(1'b0, 8'h08, 32'h0);
            chk(rd[1] === 1'b1, "fault flag");
            apb(1'b0, 8'h00, 32'h0);
            chk(rd[1:0] === 2'h0, "enables cleared");
            @(posedge pclk);
            nss0_ext <= 1'b1;
            apb(1'b1, 8'h00, 32'h0000_0707);
            chk(mosi_oe[0] === 1'b1, "re-enabled");
        end
    endtask

    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        nss0_ext = 1'b1;
        presetn = 1'b0;
        err_total = 0;
        tests_run = 0;
        edges = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset;
        t_master;
        t_slave4;
        t_slave3;
        t_fault;
        end_of_test;
    end
    // the whole run needs well under 100 us
    initial begin
        #500000;
        err_total++;
        end_of_test;
    end
endmodule // dual_serial_port_tb_top

// File: test/spi_far.sv
// far-side serial devices: a slave on port 0, a master on port 1
`timescale 1ns/1ps
module spi_far (
    input  wire  sck_m,
    input  wire  mosi_m,
    input  wire  sel_m,
    output logic miso_m,
    output logic sck_s,
    output logic mosi_s,
    output logic nss_s,
    input  wire  miso_s
);
    logic [7:0] tx_m;
    logic [7:0] rx_m;
    initial begin
        tx_m = 8'hA5;
        miso_m = 1'b1;
        sck_s = 1'b0;
        mosi_s = 1'b0;
        nss_s = 1'b1;
    end
    always @(negedge sel_m) miso_m = tx_m[7];
    always @(posedge sck_m) if (!sel_m) rx_m = {rx_m[6:0], mosi_m};
    always @(negedge sck_m) if (!sel_m) begin
        tx_m = {tx_m[6:0], tx_m[7]};
        miso_m = tx_m[7];
    end
    // a released line wanders so a stale bit cannot pass for data
    always @(posedge sel_m) miso_m = ~miso_m;

    // clock stands still between frames; offset keeps edges off pclk edges
    task automatic send(input logic [7:0] d, input logic sel, output logic [7:0] r);
        integer i;
        begin
            #7 nss_s = ~sel;
            #160;
            for (i = 7; i >= 0; i--) begin
                mosi_s = d[i];
                #80 sck_s = 1'b1;
                r = {r[6:0], miso_s};
                #80 sck_s = 1'b0;
            end
            #80 nss_s = 1'b1;
            mosi_s = ~mosi_s;
        end
    endtask
endmodule // spi_far
